// *** macrocell_port_logic.sv ***
// Output cells, input cells, pin multiplexers and readback of the logic array.
`timescale 1ns/1ps
module macrocell_port_logic (
   input  wire logic                                         clk,        // 20 MHz clock.
   input  wire logic                                         rstn,       // Sync reset, low.
   input  wire logic                                         sel,        // Register space select.
   input  wire logic [7:0]                                   addr,       // Low address byte.
   input  wire logic [7:0]                                   din,        // Write data.
   input  wire logic                                         wr_n,       // Write strobe, low.
   input  wire logic                                         rd_n,       // Read strobe, low.
   input  wire logic                                         ale,        // Address strobe.
   output logic      [7:0]                                   dout,       // Read data.
   output logic                                              dout_en,    // Drives data bus.
   input  wire logic                                         level_load, // Level load mode.
   input  wire logic_array_pkg::cell_cfg_type [15:0]         cell_cfg,   // Cell setup.
   input  wire logic_array_pkg::cell_terms_type [15:0]       terms,      // Cell terms.
   input  wire logic_array_pkg::pin_cfg_type [26:0]          pin_cfg,    // Pin setup.
   input  wire logic [26:0]                                  oe_pt,      // Enable terms.
   input  wire logic [3:0][7:0]                              port_dout,  // Data-out regs.
   input  wire logic [3:0][7:0]                              port_dir,   // Direction regs.
   input  wire logic [1:0][7:0]                              port_ctrl,  // Control regs.
   input  wire logic [5:0]                                   le_pt,      // Input enables.
   input  wire logic_array_pkg::in_cfg_type [19:0]           in_cfg,     // Input cell setup.
   input  wire logic [2:0]                                   ext_cs,     // Chip selects.
   input  wire logic [26:0]                                  pins_in,    // Pin levels.
   output logic      [26:0]                                  pins_out,   // Pin values.
   output logic      [26:0]                                  pins_oe,    // Pin enables.
   output logic      [15:0]                                  fb,         // Cell feedback.
   output logic      [19:0]                                  incell      // Input cells.
);
   import logic_array_pkg::*;

   // ****************************************************************
   // Pin input synchronisers
   // ****************************************************************
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] pin_q;
   logic            clk_pin_rise;

   // A pin level counts only once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         pin_q <= '0;
      end else begin
         s1_q  <= pins_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      end
   end

   // Rising edge of the dedicated logic clock pin after filtering.
   assign clk_pin_rise = s2_q[CLK_PIN_BIT] & s3_q[CLK_PIN_BIT] & ~pin_q[CLK_PIN_BIT];

   // ****************************************************************
   // Bus write path and masks
   // ****************************************************************
   logic       wr_act;
   logic       wr_prev_q;
   logic [7:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic       edge_fire;
   logic [7:0] mask_a_q;
   logic [7:0] mask_b_q;
   logic       hit_a;
   logic       hit_b;
   logic [7:0] ld_data;
   logic [NCELL-1:0] load_v;

   assign wr_act    = sel & ~wr_n;
   assign edge_fire = wr_prev_q & wr_n;

   // Address and data are held while the strobe is low for the trailing edge.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_prev_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end else begin
         wr_prev_q <= wr_act;
         if (wr_act) begin
            wr_addr_q <= addr;
            wr_data_q <= din;
         end
      end
   end

   // Masks are always written at the strobe's trailing edge.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_a_q <= MASK_RESET;
         mask_b_q <= MASK_RESET;
      end else if (edge_fire) begin
         if (wr_addr_q == ADDR_GA_MASK) begin
            mask_a_q <= wr_data_q;
         end
         if (wr_addr_q == ADDR_GB_MASK) begin
            mask_b_q <= wr_data_q;
         end
      end
   end

   // Level mode loads every cycle of the strobe; edge mode once at its end.
   assign hit_a   = level_load ? (wr_act && addr == ADDR_GA_DATA)
                               : (edge_fire && wr_addr_q == ADDR_GA_DATA);
   assign hit_b   = level_load ? (wr_act && addr == ADDR_GB_DATA)
                               : (edge_fire && wr_addr_q == ADDR_GB_DATA);
   assign ld_data = level_load ? din : wr_data_q;
   // A set mask bit keeps software away from that cell.
   assign load_v  = {hit_b ? ~mask_b_q : 8'h00, hit_a ? ~mask_a_q : 8'h00};

   // ****************************************************************
   // Output cells
   // ****************************************************************
   logic [NCELL-1:0] cell_q;
   logic [NCELL-1:0] ptclk_q;
   logic [NCELL-1:0] exp_q;
   logic [NCELL-1:0] sum_w;
   logic [NCELL-1:0] xr_w;
   logic [NCELL-1:0] out_c;
   logic [NCELL-1:0] fb_q;

   for (genvar g = 0; g < NCELL; g++) begin : g_cell
      localparam int DON = g ^ 1;
      localparam int EXP = (g & GRP) | ((g + 2) % GRP);
      localparam logic [3:0] NAT = (g < GRP) ? NATIVE_A : NATIVE_B;
      logic [3:0] own;
      logic [3:0] lent;
      logic       clk_en;

      // Borrowed terms are only those the fixed donor leaves unused.
      assign own  = terms[g].sum & cell_cfg[g].use_terms & NAT;
      assign lent = terms[DON].sum & ~cell_cfg[DON].use_terms & NAT
                  & cell_cfg[g].borrow;
      // Expansion goes through another cell and costs a cycle of delay.
      assign sum_w[g]  = (|own) | (|lent) | (cell_cfg[g].expand & exp_q[g]);
      assign xr_w[g]   = sum_w[g] ^ cell_cfg[g].invert;
      assign out_c[g]  = cell_cfg[g].registered ? cell_q[g] : xr_w[g];
      assign clk_en    = cell_cfg[g].clk_pin ? clk_pin_rise
                                             : (terms[g].clk & ~ptclk_q[g]);

      // Load beats clear, clear beats preset, and both beat the clock.
      always_ff @(posedge clk) begin
         if (!rstn) begin
            cell_q[g]  <= 1'b0;
            ptclk_q[g] <= 1'b0;
            exp_q[g]   <= 1'b0;
         end else begin
            ptclk_q[g] <= terms[g].clk;
            exp_q[g]   <= sum_w[EXP];
            if (load_v[g]) begin
               cell_q[g] <= ld_data[g % GRP];
            end else if (|terms[g].clr) begin
               cell_q[g] <= 1'b0;
            end else if (terms[g].pre) begin
               cell_q[g] <= 1'b1;
            end else if (clk_en) begin
               unique case (cell_cfg[g].kind)
                  FF_D:  cell_q[g] <= xr_w[g];
                  FF_T:  cell_q[g] <= cell_q[g] ^ xr_w[g];
                  FF_JK: cell_q[g] <= (xr_w[g] & ~cell_q[g]) | (~terms[g].k & cell_q[g]);
                  FF_SR: cell_q[g] <= ~terms[g].k & (xr_w[g] | cell_q[g]);
               endcase
            end
         end
      end
   end

   // Feedback to the array exists whether or not the cell reaches a pin.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fb_q <= '0;
      end else begin
         fb_q <= out_c;
      end
   end

   // ****************************************************************
   // Pin multiplexers and driver enables
   // ****************************************************************
   logic [7:0]      addr_lat_q;
   logic [NPIN-1:0] pval_w;
   logic [NPIN-1:0] poe_w;
   logic [NPIN-1:0] out_q;
   logic [NPIN-1:0] oe_q;

   // Address latched by the strobe for address-out pins.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         addr_lat_q <= 8'h00;
      end else if (ale) begin
         addr_lat_q <= addr;
      end
   end

   for (genvar k = 0; k < NPIN; k++) begin : g_pin
      localparam int P = k / GRP;
      localparam int N = k % GRP;
      logic drive;
      logic src;
      if (P == 0) begin : g_a
         assign drive = pin_cfg[k].cell_drive;
         assign src   = drive ? out_c[N] : (port_ctrl[0][N] ? addr_lat_q[N]
                                                            : port_dout[0][N]);
      end else if (P == 1) begin : g_b
         assign drive = pin_cfg[k].cell_drive;
         assign src   = drive ? (pin_cfg[k].from_b ? out_c[GRP + N] : out_c[N])
                              : (port_ctrl[1][N] ? addr_lat_q[N] : port_dout[1][N]);
      end else if (P == 2) begin : g_c
         // Test access pins never see a cell value.
         assign drive = pin_cfg[k].cell_drive & C_CELL_OK[N];
         assign src   = drive ? out_c[GRP + N] : port_dout[2][N];
      end else begin : g_d
         assign drive = pin_cfg[k].cell_drive;
         assign src   = drive ? ext_cs[N] : port_dout[3][N];
      end
      assign pval_w[k] = src;
      // Logic outputs with no enable equation are always driven.
      assign poe_w[k]  = (drive & ~pin_cfg[k].oe_eq)
                       | (pin_cfg[k].oe_eq & oe_pt[k]) | port_dir[P][N];
   end

   // Every pin is set up on its own from its own configuration bits.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_q <= '0;
         oe_q  <= '0;
      end else begin
         out_q <= pval_w;
         oe_q  <= poe_w;
      end
   end

   // ****************************************************************
   // Input cells
   // ****************************************************************
   logic [NIN-1:0] in_q;
   logic [NIN-1:0] en_q;

   for (genvar j = 0; j < NIN; j++) begin : g_in
      localparam int PI = (j < BASE_C) ? j : BASE_C + ((j == 16) ? 2 : (j == 17) ? 3
                                                      : (j == 18) ? 4 : 7);
      localparam int LG = (j < BASE_C) ? j / 4 : ((j < 18) ? 4 : 5);
      logic en;
      assign en = in_cfg[j].by_ale ? ale : le_pt[LG];

      // Register mode needs an edge, so the enable is remembered per cell.
      always_ff @(posedge clk) begin
         if (!rstn) begin
            in_q[j] <= 1'b0;
            en_q[j] <= 1'b0;
         end else begin
            en_q[j] <= en;
            case (in_cfg[j].mode)
               IN_PASS:  in_q[j] <= pin_q[PI];
               IN_LATCH: if (en) begin
                  in_q[j] <= pin_q[PI];
               end
               IN_REG:   if (en && !en_q[j]) begin
                  in_q[j] <= pin_q[PI];
               end
               default:  in_q[j] <= in_q[j];
            endcase
         end
      end
   end

   // ****************************************************************
   // Readback buffer
   // ****************************************************************
   logic [3:0][7:0] pin_rd;
   logic [3:0][7:0] mux_rd;
   logic [3:0][7:0] in_rd;
   logic [3:0][7:0] ctrl_rd;
   logic [7:0]      rd_val;
   logic            rd_cond;
   logic [7:0]      dout_q;
   logic            dout_en_q;

   assign pin_rd  = {5'h00, pin_q};
   assign mux_rd  = {5'h00, out_q};
   assign in_rd   = {8'h00, in_q[19], 2'h0, in_q[18:16], 2'h0, in_q[15:0]};
   assign ctrl_rd = {16'h0000, port_ctrl};
   assign rd_cond = sel & ~rd_n;

   // Only one source reaches the bus; unmapped addresses read as zero.
   always_comb begin
      rd_val = 8'h00;
      case (addr[7:2])
         ADDR_PIN_IN[7:2]: rd_val = pin_rd[addr[1:0]];
         ADDR_DOUT[7:2]:   rd_val = port_dout[addr[1:0]];
         ADDR_DIR[7:2]:    rd_val = port_dir[addr[1:0]];
         ADDR_CTRL[7:2]:   rd_val = ctrl_rd[addr[1:0]];
         ADDR_INCELL[7:2]: rd_val = in_rd[addr[1:0]];
         ADDR_PINMUX[7:2]: rd_val = mux_rd[addr[1:0]];
         ADDR_GA_DATA[7:2]: begin
            if (addr == ADDR_GA_DATA) begin
               rd_val = cell_q[7:0];
            end else if (addr == ADDR_GB_DATA) begin
               rd_val = cell_q[15:8];
            end else if (addr == ADDR_GA_MASK) begin
               rd_val = mask_a_q;
            end else begin
               rd_val = mask_b_q;
            end
         end
         default:          rd_val = 8'h00;
      endcase
   end

   // Read data is registered; it appears one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dout_q    <= 8'h00;
         dout_en_q <= 1'b0;
      end else begin
         dout_en_q <= rd_cond;
         if (rd_cond) begin
            dout_q <= rd_val;
         end
      end
   end

   assign dout     = dout_q;
   assign dout_en  = dout_en_q;
   assign pins_out = out_q;
   assign pins_oe  = oe_q;
   assign fb       = fb_q;
   assign incell   = in_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   mask_gate_a: assert property ((load_v & {mask_b_q, mask_a_q}) == 16'h0000)
      else $error("masked cell was loaded");
   load_prio_a: assert property (load_v[0] |=> cell_q[0] == $past(ld_data[0]))
      else $error("load did not win");
   edge_load_a: assert property (!level_load && |load_v |-> wr_n && $past(wr_act))
      else $error("edge load away from trailing edge");
   level_load_a: assert property (level_load && wr_act && addr == ADDR_GA_DATA
                                  |-> load_v[7:0] == ~mask_a_q)
      else $error("level load missing");
   clear_wins_a: assert property (!load_v[1] && |terms[1].clr |=> !cell_q[1])
      else $error("clear ignored");
   pin_clock_a: assert property (!load_v[2] && !(|terms[2].clr) && !terms[2].pre
                                 && cell_cfg[2].clk_pin && cell_cfg[2].kind == FF_D
                                 && clk_pin_rise |=> cell_q[2] == $past(xr_w[2]))
      else $error("pin clock did not update cell");
   oe_dir_a: assert property (port_dir[0][3] |=> oe_q[3])
      else $error("direction bit did not enable driver");
   jtag_free_a: assert property (##1 out_q[BASE_C] == $past(port_dout[2][0]))
      else $error("test pin carried a cell value");
   read_one_a: assert property (rd_cond && addr == ADDR_GA_MASK
                                |=> dout_en_q && dout_q == $past(mask_a_q))
      else $error("wrong readback source");
   pass_in_a: assert property (in_cfg[0].mode == IN_PASS |=> in_q[0] == $past(pin_q[0]))
      else $error("pass input cell lagging");

   load_cov_c: cover property (hit_a ##1 rd_cond && addr == ADDR_GA_DATA);
   jk_cov_c: cover property (cell_cfg[4].kind == FF_JK && terms[4].clk && !ptclk_q[4]);
   reg_in_cov_c: cover property (in_cfg[5].mode == IN_REG && le_pt[1] && !en_q[5]);
endmodule

// *** logic_array_pkg.sv ***
// Constants, types and carriers shared by the macrocell and port logic.
// ****************************************************************
// What this block does
// - Sixteen output cells in two groups; group a drives ports A/B, b drives B/C.
// - Term sum passes polarity XOR, then registered or combinatorial mux to pin and feedback.
// - Each output cell flip-flop acts as D, T, JK or SR storage.
// - Clock, preset, clear come from terms; clock may be dedicated pin rising edge.
// - Preset and clear are active high; clear may use two terms.
// - Group a: three native terms; group b: four native terms; fixed borrow limits.
// - A term used by one cell is unavailable to others; fixed donors only.
// - Extra terms come from another cell and add delay to that output.
// - Software loads and reads all sixteen flip-flops; cell n maps to bit n mod 8 of its group's data byte.
// - A software load overrides preset, clear and clock of that flip-flop.
// - Load happens at write strobe trailing edge or throughout the strobe, per configuration.
// - Per-group eight-bit mask resets to zero; a one blocks loading that cell.
// - Pin driver enable is enable term ORed with the direction bit.
// - Logic output without enable equation is held off during reset and drives from the first clock after reset onward.
// - A cell used as internal node still feeds back and frees its pin.
// - Twenty input cells: pass, latch or register, all readable by software.
// - Input cell enable is a term or address strobe; one term per four bits for cells 0-15, one per two bits for cells 16-19.
// - Pin mux picks data-out, latched address, cell output or external chip select.
// - Readback returns exactly one selected source per access.
// - Without enable term and not a logic output, direction bit alone drives enable.
// - Ports A, B, C are eight bits, port D three; pins configured individually.
// - Port C pins 0, 1, 5, 6 never carry output cell values.
// ****************************************************************
package logic_array_pkg;
   localparam int NCELL = 16;
   localparam int GRP   = 8;
   localparam int NIN   = 20;
   localparam int NPIN  = 27;
   localparam int NLE   = 6;
   localparam int BASE_B = 8;
   localparam int BASE_C = 16;
   localparam int BASE_D = 24;
   localparam int CLK_PIN_BIT = 25;
   localparam logic [7:0] ADDR_PIN_IN  = 8'h00;
   localparam logic [7:0] ADDR_DOUT    = 8'h04;
   localparam logic [7:0] ADDR_DIR     = 8'h08;
   localparam logic [7:0] ADDR_CTRL    = 8'h0c;
   localparam logic [7:0] ADDR_INCELL  = 8'h10;
   localparam logic [7:0] ADDR_PINMUX  = 8'h14;
   localparam logic [7:0] ADDR_GA_DATA = 8'h20;
   localparam logic [7:0] ADDR_GB_DATA = 8'h21;
   localparam logic [7:0] ADDR_GA_MASK = 8'h22;
   localparam logic [7:0] ADDR_GB_MASK = 8'h23;
   localparam logic [7:0] MASK_RESET   = 8'h00;
   localparam logic [3:0] NATIVE_A     = 4'h7;
   localparam logic [3:0] NATIVE_B     = 4'hf;
   localparam logic [7:0] C_CELL_OK    = 8'h9c;
   typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_type;
   typedef enum logic [1:0] {IN_PASS, IN_LATCH, IN_REG} in_mode_type;
   typedef struct packed {
      ff_kind_type kind;
      logic        invert;
      logic        registered;
      logic        clk_pin;
      logic        expand;
      logic [3:0]  use_terms;
      logic [3:0]  borrow;
   } cell_cfg_type;
   typedef struct packed {
      logic [3:0] sum;
      logic       k;
      logic       clk;
      logic       pre;
      logic [1:0] clr;
   } cell_terms_type;
   typedef struct packed {
      logic cell_drive;
      logic from_b;
      logic oe_eq;
   } pin_cfg_type;
   typedef struct packed {
      in_mode_type mode;
      logic        by_ale;
   } in_cfg_type;
endpackage

// *** pin_partner.sv ***
// Board model around the port pins of the logic array.
`timescale 1ns/1ps
module pin_partner (
   input  wire logic [26:0] pins_out, // Device pin values.
   input  wire logic [26:0] pins_oe,  // Device pin enables.
   input  wire logic [26:0] ext_val,  // Board level on each pin.
   output logic      [26:0] pins_in   // Resolved pin levels.
);
   // A driven pin shows the device value; a released one falls to the board level,
   // so a stale device value can never be read back by mistake.
   assign pins_in = (pins_out & pins_oe) | (ext_val & ~pins_oe);
endmodule

// *** macrocell_port_logic_tb.sv ***
// Self-checking bench for the output cells, input cells and pin logic.
`timescale 1ns/1ps
module macrocell_port_logic_tb;
   import logic_array_pkg::*;
   localparam time DLY = 2ns;
   logic                  clk, rstn, sel, wr_n, rd_n, ale, level_load, dout_en;
   logic [7:0]            addr, din, dout;
   cell_cfg_type [15:0]   cell_cfg;
   cell_terms_type [15:0] terms;
   pin_cfg_type [26:0]    pin_cfg;
   logic [26:0]           oe_pt, pins_in, pins_out, pins_oe, ext_val;
   logic [3:0][7:0]       port_dout, port_dir;
   logic [1:0][7:0]       port_ctrl;
   logic [5:0]            le_pt;
   in_cfg_type [19:0]     in_cfg;
   logic [2:0]            ext_cs;
   logic [15:0]           fb;
   logic [19:0]           incell;
   int                    mismatches, n_compared;

   macrocell_port_logic macrocell_port_logic_i (
      .clk(clk), .rstn(rstn), .sel(sel), .addr(addr), .din(din), .wr_n(wr_n),
      .rd_n(rd_n), .ale(ale), .dout(dout), .dout_en(dout_en), .level_load(level_load),
      .cell_cfg(cell_cfg), .terms(terms), .pin_cfg(pin_cfg), .oe_pt(oe_pt),
      .port_dout(port_dout), .port_dir(port_dir), .port_ctrl(port_ctrl), .le_pt(le_pt),
      .in_cfg(in_cfg), .ext_cs(ext_cs), .pins_in(pins_in), .pins_out(pins_out),
      .pins_oe(pins_oe), .fb(fb), .incell(incell));

   pin_partner pin_partner_i (.pins_out(pins_out), .pins_oe(pins_oe), .ext_val(ext_val),
      .pins_in(pins_in));

   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // *************************************
   // Bus and compare tasks
   // *************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask

   // Byte write; the trailing strobe edge falls one cycle later, then the cell settles.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sel = 1'b1;
      wr_n = 1'b0;
      addr = a;
      din = d;
      @(posedge clk);
      #DLY;
      sel = 1'b0;
      wr_n = 1'b1;
      repeat (2) @(posedge clk);
      #DLY;
   endtask

   // Byte read; data stands one edge after the strobe cycle.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sel = 1'b1;
      rd_n = 1'b0;
      addr = a;
      @(posedge clk);
      #DLY;
      sel = 1'b0;
      rd_n = 1'b1;
      chk1(dout_en, 1'b1);
      chk8(dout, exp);
      @(posedge clk);
      #DLY;
   endtask

   task automatic final_report();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog so that a stuck run still ends in the report.
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      $display("BAD %0t run timed out", $time);
      final_report();
   end

   // Main sequence: undriven port B floats to 5a from the board model.
   initial begin
      {rstn, sel, ale, level_load, addr, din} = '0;
      {wr_n, rd_n} = 2'b11;
      {cell_cfg, terms, pin_cfg, oe_pt, port_dout, port_dir} = '0;
      {port_ctrl, le_pt, in_cfg, mismatches, n_compared} = '0;
      for (int i = 0; i < 16; i++) begin
         cell_cfg[i].registered = 1'b1;
      end
      pin_cfg[0].oe_eq = 1'b1;
      pin_cfg[2].cell_drive = 1'b1;
      pin_cfg[24].cell_drive = 1'b1;
      pin_cfg[16].cell_drive = 1'b1;
      pin_cfg[18].cell_drive = 1'b1;
      oe_pt[1:0] = 2'b11;
      port_dout[0] = 8'h02;
      port_dir[0] = 8'h18;
      ext_cs = 3'h1;
      ext_val = 27'h0005a00;
      repeat (3) @(posedge clk);
      #DLY;
      rstn = 1'b1;
      @(posedge clk);
      #DLY;
      rd(ADDR_GA_MASK, MASK_RESET);
      rd(ADDR_GB_MASK, MASK_RESET);
      wr(ADDR_GA_DATA, 8'ha5);
      rd(ADDR_GA_DATA, 8'ha5);
      chk8(fb[7:0], 8'ha5);
      chk1(pins_out[2], 1'b1);
      chk1(pins_oe[0], 1'b1);
      chk1(pins_oe[1], 1'b0);
      chk1(pins_oe[2], 1'b1);
      chk1(pins_oe[4], 1'b1);
      chk1(pins_out[1], 1'b1);
      chk1(pins_out[24], 1'b1);
      wr(ADDR_GA_MASK, 8'h0f);
      wr(ADDR_GA_DATA, 8'h00);
      rd(ADDR_GA_DATA, 8'h05);
      rd(ADDR_GA_MASK, 8'h0f);
      level_load = 1'b1;
      wr(ADDR_GB_DATA, 8'h3d);
      rd(ADDR_GB_DATA, 8'h3d);
      chk1(pins_out[16], 1'b0);
      chk1(pins_out[18], 1'b1);
      wr(ADDR_GA_DATA, 8'hff);
      rd(ADDR_GA_DATA, 8'hf5);
      level_load = 1'b0;
      // Preset sets cell 1; clear and preset together must leave it clear.
      terms[1].pre = 1'b1;
      @(posedge clk);
      #DLY;
      terms[1].pre = 1'b0;
      rd(ADDR_GA_DATA, 8'hf7);
      terms[1].pre = 1'b1;
      terms[1].clr = 2'b10;
      @(posedge clk);
      #DLY;
      terms[1].pre = 1'b0;
      terms[1].clr = 2'b00;
      rd(ADDR_GA_DATA, 8'hf5);
      // Cell 2 clocks from the logic clock pin; cells 3, 5 and 6 bypass their flip-flops.
      cell_cfg[2].clk_pin = 1'b1;
      cell_cfg[3].registered = 1'b0;
      cell_cfg[3].invert = 1'b1;
      cell_cfg[5].registered = 1'b0;
      cell_cfg[5].borrow = 4'h1;
      terms[4].sum = 4'h1;
      cell_cfg[6].registered = 1'b0;
      cell_cfg[6].use_terms = 4'h8;
      terms[6].sum = 4'h8;
      ext_val[25] = 1'b1;
      repeat (6) @(posedge clk);
      #DLY;
      rd(ADDR_GA_DATA, 8'hf1);
      chk1(fb[3], 1'b1);
      chk1(fb[5], 1'b1);
      chk1(fb[6], 1'b0);
      // An address-out pin shows the address captured by the strobe.
      addr = 8'h20;
      ale = 1'b1;
      port_ctrl[0] = 8'h20;
      @(posedge clk);
      #DLY;
      ale = 1'b0;
      @(posedge clk);
      #DLY;
      chk1(pins_out[5], 1'b1);
      rd(ADDR_CTRL, 8'h20);
      rd(ADDR_PIN_IN + 8'h01, 8'h5a);
      rd(ADDR_DIR, 8'h18);
      rd(ADDR_INCELL + 8'h01, 8'h5a);
      rd(8'h30, 8'h00);
      final_report();
   end
endmodule
